// ---- logic/rtccal_pkg.sv ----
// rtccal_pkg: register map, field layout and counting constants
// assumes 32-bit byte addresses and a one-cycle 32 kHz tick in sys_clk
package rtccal_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_CONTROL = 32'h40006004;
    localparam logic [31:0] ADDR_STATUS = 32'h40006008;
    localparam logic [31:0] ADDR_WEEKDAY_BUFFER = 32'h40006020;
    localparam logic [31:0] ADDR_DAY_BUFFER = 32'h40006024;
    localparam logic [31:0] ADDR_MONTH_BUFFER = 32'h40006028;
    localparam logic [31:0] ADDR_YEAR_BUFFER = 32'h4000602C;
    localparam logic [31:0] ADDR_PACKED_TIME_SET = 32'h40006030;
    localparam logic [31:0] ADDR_PACKED_CALENDAR_SET = 32'h40006034;
    localparam logic [31:0] ADDR_ERROR_CORRECTION = 32'h40006038;
    localparam logic [31:0] ADDR_SUBCOUNT_COMPARE = 32'h4000603C;
    localparam logic [31:0] ADDR_ALARM_MINUTE = 32'h40006040;
    localparam logic [31:0] ADDR_ALARM_HOUR = 32'h40006044;
    localparam logic [31:0] ADDR_ALARM_WEEKDAY_ENABLE = 32'h40006048;
    localparam logic [31:0] ADDR_SECONDS_COUNT = 32'h4000604C;
    // control register bit positions
    localparam int CTL_COUNTER_ENABLE = 0;
    localparam int CTL_WAIT = 1;
    localparam int CTL_SUB_SOURCE_SEL = 2;
    localparam int CTL_HOUR_FORMAT_SEL = 3;
    // status register bit positions
    localparam int STS_COMPARE_WRITE = 0;
    localparam int STS_OVF_HELD = 1;
    // error correction register bit positions
    localparam int CORR_TIMING_BIT = 7;
    localparam int CORR_SIGN_BIT = 6;
    // packed word field positions
    localparam int PT_HOUR_LSB = 16;
    localparam int PT_MINUTE_LSB = 8;
    localparam int PT_SECOND_LSB = 0;
    localparam int PC_YEAR_LSB = 24;
    localparam int PC_MONTH_LSB = 16;
    localparam int PC_DAY_LSB = 8;
    localparam int PC_WEEKDAY_LSB = 0;
    // values after reset
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    localparam logic [21:0] COMPARE_RESET = 22'h000000;
    localparam logic [7:0] CORR_RESET = 8'h00;
    // sub-counter limits
    localparam logic [21:0] SUB_NOMINAL_LAST = 22'h007FFF;
    localparam logic [21:0] SUB_CORR_BIAS = 22'h000002;
    // seconds at which correction may apply, and the last second 59
    localparam logic [6:0] SEC_00 = 7'h00;
    localparam logic [6:0] SEC_20 = 7'h20;
    localparam logic [6:0] SEC_40 = 7'h40;
    localparam logic [6:0] SEC_LAST = 7'h59;
    // largest BCD digits
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [2:0] MIN_TENS_MAX = 3'h5;
    localparam logic [1:0] HOUR24_TENS_MAX = 2'h2;
    localparam logic [3:0] HOUR24_UNITS_AT_TWENTY = 4'h3;
    localparam logic [3:0] HOUR12_UNITS_AT_TEN = 4'h2;
endpackage

// ---- logic/rtccal_regs.sv ----
// rtccal_regs: calendar buffers, sub-counter with correction or compare,
// seconds counter and alarm detect of the real-time clock
// assumes tick_32k is a one-cycle pulse per 32 kHz edge, synchronous to
// sys_clk, and that minute, hour and weekday counts come from outside
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////
// Overview of operation
// - packed time word reaches hour, minute, second buffers at once
// - packed calendar word reaches year, month, day, weekday at once
// - correction at seconds 00/20/40, or only 00 when timing bit set
// - sign 0 lengthens by (F-1)*2; sign 1 shortens by (~F+1)*2
// - compare value used when source select is 1; match overflows, clears
// - compare write while running completes at next sub-counter overflow
// - out-of-range alarm minute suppresses alarm detection
// - out-of-range alarm hour for the format suppresses alarm detection
// - seven weekday enable bits, bit n enables weekday value n
// - seconds count 00..59 in BCD, pulse to minutes on 59 to 00
// - weekday, compare, alarm minute reset to zero; reserved bits read 0
// - without compare or correction sub-counter runs 0..7FFFh then overflows
// - hour format select 0 is 12-hour with bit 5 pm, 1 is 24-hour
module rtccal_regs
    import rtccal_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic tick_32k,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [6:0] minute_counter,
    input wire logic [5:0] hour_counter,
    input wire logic [2:0] weekday_counter,
    output logic minute_carry,
    output logic alarm_event
);

    logic [3:0] control;
    logic [2:0] weekday_buf;
    logic [5:0] day_buf;
    logic [4:0] month_buf;
    logic [7:0] year_buf;
    logic [5:0] hour_buf;
    logic [6:0] minute_buf;
    logic [6:0] second_buf;
    logic [7:0] err_corr_reg;
    logic [21:0] sub_compare;
    logic [21:0] compare_pending;
    logic compare_write_status;
    logic [6:0] alarm_min;
    logic [5:0] alarm_hr;
    logic [6:0] alarm_day_en;
    logic [21:0] sub_counter;
    logic [6:0] second_counter;
    logic ovf_held;
    logic alarm_match_q;

    logic counter_enable;
    logic wait_req;
    logic sub_source_sel;
    logic hour_format_sel;
    logic wr_time;
    logic wr_cal;
    logic wr_compare;
    logic corr_now;
    logic [21:0] corr_amount;
    logic [21:0] sub_last;
    logic sub_ovf;
    logic sec_step;
    logic [6:0] next_second;
    logic min_ok;
    logic hr_ok;
    logic alarm_match;

    assign counter_enable = control[CTL_COUNTER_ENABLE];
    assign wait_req = control[CTL_WAIT];
    assign sub_source_sel = control[CTL_SUB_SOURCE_SEL];
    assign hour_format_sel = control[CTL_HOUR_FORMAT_SEL];
    assign wr_time = reg_wr && (reg_addr == ADDR_PACKED_TIME_SET);
    assign wr_cal = reg_wr && (reg_addr == ADDR_PACKED_CALENDAR_SET);
    assign wr_compare = reg_wr && (reg_addr == ADDR_SUBCOUNT_COMPARE);

    //////////////////////////////////////////////////////////////////////
    // sub-counter limit
    always_comb begin
        corr_now = (second_counter == SEC_00) ||
            (!err_corr_reg[CORR_TIMING_BIT] &&
            ((second_counter == SEC_20) || (second_counter == SEC_40)));
        // magnitude times two, the bias of 2 is taken off below
        corr_amount = {15'h0000, err_corr_reg[5:0], 1'b0};
        if (err_corr_reg[CORR_SIGN_BIT]) begin
            corr_amount = {15'h0000, ~err_corr_reg[5:0], 1'b0};
        end
        if (sub_source_sel) begin
            sub_last = sub_compare;
        end else if (!corr_now) begin
            sub_last = SUB_NOMINAL_LAST;
        end else if (!err_corr_reg[CORR_SIGN_BIT]) begin
            sub_last = SUB_NOMINAL_LAST + corr_amount - SUB_CORR_BIAS;
        end else begin
            sub_last = SUB_NOMINAL_LAST - corr_amount - SUB_CORR_BIAS;
        end
    end

    assign sub_ovf = counter_enable && tick_32k && (sub_counter == sub_last);

    //////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            control <= CONTROL_RESET;
        end else if (clk_en && reg_wr && (reg_addr == ADDR_CONTROL)) begin
            control <= reg_wdata[3:0];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // calendar buffers, direct and packed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            weekday_buf <= 3'h0;
            day_buf <= 6'h00;
            month_buf <= 5'h00;
            year_buf <= 8'h00;
        end else if (clk_en) begin
            if (wr_cal) begin
                year_buf <= reg_wdata[PC_YEAR_LSB +: 8];
                month_buf <= reg_wdata[PC_MONTH_LSB +: 5];
                day_buf <= reg_wdata[PC_DAY_LSB +: 6];
                weekday_buf <= reg_wdata[PC_WEEKDAY_LSB +: 3];
            end
            if (reg_wr && (reg_addr == ADDR_WEEKDAY_BUFFER)) begin
                weekday_buf <= reg_wdata[2:0];
            end
            if (reg_wr && (reg_addr == ADDR_DAY_BUFFER)) begin
                day_buf <= reg_wdata[5:0];
            end
            if (reg_wr && (reg_addr == ADDR_MONTH_BUFFER)) begin
                month_buf <= reg_wdata[4:0];
            end
            if (reg_wr && (reg_addr == ADDR_YEAR_BUFFER)) begin
                year_buf <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hour_buf <= 6'h00;
            minute_buf <= 7'h00;
            second_buf <= 7'h00;
        end else if (clk_en && wr_time) begin
            hour_buf <= reg_wdata[PT_HOUR_LSB +: 6];
            minute_buf <= reg_wdata[PT_MINUTE_LSB +: 7];
            second_buf <= reg_wdata[PT_SECOND_LSB +: 7];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // correction, compare and alarm settings
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            err_corr_reg <= CORR_RESET;
            alarm_min <= 7'h00;
            alarm_hr <= 6'h00;
            alarm_day_en <= 7'h00;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == ADDR_ERROR_CORRECTION) begin
                err_corr_reg <= reg_wdata[7:0];
            end
            if (reg_addr == ADDR_ALARM_MINUTE) begin
                alarm_min <= reg_wdata[6:0];
            end
            if (reg_addr == ADDR_ALARM_HOUR) begin
                alarm_hr <= reg_wdata[5:0];
            end
            if (reg_addr == ADDR_ALARM_WEEKDAY_ENABLE) begin
                alarm_day_en <= reg_wdata[6:0];
            end
        end
    end

    // running writes wait for the overflow so the period never tears
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sub_compare <= COMPARE_RESET;
            compare_pending <= COMPARE_RESET;
            compare_write_status <= 1'b0;
        end else if (clk_en) begin
            if (wr_compare && !counter_enable) begin
                sub_compare <= reg_wdata[21:0];
                compare_write_status <= 1'b0;
            end else if (wr_compare) begin
                compare_pending <= reg_wdata[21:0];
                compare_write_status <= 1'b1;
            end else if (compare_write_status &&
                (sub_ovf || !counter_enable)) begin
                sub_compare <= compare_pending;
                compare_write_status <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // sub-counter and overflow hold under wait
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sub_counter <= 22'h000000;
        end else if (clk_en) begin
            if (wr_time) begin
                sub_counter <= 22'h000000;
            end else if (sub_ovf) begin
                sub_counter <= 22'h000000;
            end else if (counter_enable && tick_32k) begin
                sub_counter <= sub_counter + 22'h000001;
            end
        end
    end

    assign sec_step = !wait_req && (sub_ovf || ovf_held);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ovf_held <= 1'b0;
        end else if (clk_en) begin
            if (wr_time) begin
                ovf_held <= 1'b0;
            end else if (wait_req && sub_ovf) begin
                ovf_held <= 1'b1;
            end else if (!wait_req) begin
                ovf_held <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // seconds count in BCD
    always_comb begin
        next_second = second_counter;
        if (second_counter == SEC_LAST) begin
            next_second = SEC_00;
        end else if (second_counter[3:0] == BCD_NINE) begin
            next_second = {second_counter[6:4] + 3'h1, 4'h0};
        end else begin
            next_second = {second_counter[6:4], second_counter[3:0] + 4'h1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            second_counter <= 7'h00;
            minute_carry <= 1'b0;
        end else if (clk_en) begin
            minute_carry <= 1'b0;
            if (wr_time) begin
                second_counter <= reg_wdata[PT_SECOND_LSB +: 7];
            end else if (sec_step) begin
                second_counter <= next_second;
                minute_carry <= (second_counter == SEC_LAST);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // alarm detect
    always_comb begin
        min_ok = (alarm_min[6:4] <= MIN_TENS_MAX) &&
            (alarm_min[3:0] <= BCD_NINE);
        if (hour_format_sel) begin
            hr_ok = (alarm_hr[3:0] <= BCD_NINE) &&
                ((alarm_hr[5:4] < HOUR24_TENS_MAX) ||
                ((alarm_hr[5:4] == HOUR24_TENS_MAX) &&
                (alarm_hr[3:0] <= HOUR24_UNITS_AT_TWENTY)));
        end else begin
            // bit 5 marks pm, bit 4 the tens of 10..12
            hr_ok = alarm_hr[4] ?
                (alarm_hr[3:0] <= HOUR12_UNITS_AT_TEN) :
                ((alarm_hr[3:0] != 4'h0) && (alarm_hr[3:0] <= BCD_NINE));
        end
        alarm_match = min_ok && hr_ok &&
            (minute_counter == alarm_min) && (hour_counter == alarm_hr) &&
            alarm_day_en[weekday_counter];
    end

    // one pulse when the match begins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            alarm_match_q <= 1'b0;
            alarm_event <= 1'b0;
        end else if (clk_en) begin
            alarm_match_q <= alarm_match;
            alarm_event <= alarm_match && !alarm_match_q;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_CONTROL: reg_rdata <= {28'h0000000, control};
                    ADDR_STATUS: reg_rdata <= {30'h00000000, ovf_held,
                        compare_write_status};
                    ADDR_WEEKDAY_BUFFER: reg_rdata <= {29'h0, weekday_buf};
                    ADDR_DAY_BUFFER: reg_rdata <= {26'h0, day_buf};
                    ADDR_MONTH_BUFFER: reg_rdata <= {27'h0, month_buf};
                    ADDR_YEAR_BUFFER: reg_rdata <= {24'h0, year_buf};
                    ADDR_PACKED_TIME_SET: reg_rdata <= {8'h00, 2'h0,
                        hour_buf, 1'b0, minute_buf, 1'b0, second_buf};
                    ADDR_PACKED_CALENDAR_SET: reg_rdata <= {year_buf,
                        3'h0, month_buf, 2'h0, day_buf, 5'h00, weekday_buf};
                    ADDR_ERROR_CORRECTION: reg_rdata <= {24'h0, err_corr_reg};
                    ADDR_SUBCOUNT_COMPARE: reg_rdata <= {10'h000, sub_compare};
                    ADDR_ALARM_MINUTE: reg_rdata <= {25'h0, alarm_min};
                    ADDR_ALARM_HOUR: reg_rdata <= {26'h0, alarm_hr};
                    ADDR_ALARM_WEEKDAY_ENABLE: reg_rdata <= {25'h0,
                        alarm_day_en};
                    ADDR_SECONDS_COUNT: reg_rdata <= {25'h0, second_counter};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// ---- bench/rtccal_regs_monitor.sv ----
// rtccal_regs_monitor: port-level assertions for rtccal_regs
// assumes one clock sys_clk and synchronous active-low rst_n
`timescale 1ns/10ps
module rtccal_regs_monitor
    import rtccal_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic tick_32k,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [6:0] minute_counter,
    input wire logic [5:0] hour_counter,
    input wire logic [2:0] weekday_counter,
    input wire logic minute_carry,
    input wire logic alarm_event
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd(logic [31:0] a);
        clk_en && reg_rd && reg_addr == a;
    endsequence
    sequence s_wr(logic [31:0] a);
        clk_en && reg_wr && reg_addr == a;
    endsequence

    property p_rdata_idle;
        clk_en && !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
    property p_wk_rsvd;
        s_rd(ADDR_WEEKDAY_BUFFER) |=> reg_rdata[31:3] == 29'h0;
    endproperty
    a_wk_rsvd: assert property (p_wk_rsvd)
        else $error("weekday reserved bits not zero");
    property p_sec_bcd;
        s_rd(ADDR_SECONDS_COUNT) |=> reg_rdata[31:7] == 25'h0
            && reg_rdata[3:0] <= BCD_NINE && reg_rdata[6:4] <= MIN_TENS_MAX;
    endproperty
    a_sec_bcd: assert property (p_sec_bcd)
        else $error("seconds count out of range");
    property p_carry_once;
        minute_carry |=> !minute_carry;
    endproperty
    a_carry_once: assert property (p_carry_once)
        else $error("minute carry longer than one cycle");
    property p_alarm_once;
        alarm_event |=> !alarm_event;
    endproperty
    a_alarm_once: assert property (p_alarm_once)
        else $error("alarm event longer than one cycle");
    property p_alarm_min;
        alarm_event |-> $past(minute_counter[3:0]) <= BCD_NINE
            && $past(minute_counter[6:4]) <= MIN_TENS_MAX;
    endproperty
    a_alarm_min: assert property (p_alarm_min)
        else $error("alarm on invalid minute");
    property p_wk_loop;
        s_wr(ADDR_WEEKDAY_BUFFER) ##2 s_rd(ADDR_WEEKDAY_BUFFER)
            |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3);
    endproperty
    a_wk_loop: assert property (p_wk_loop)
        else $error("weekday readback differs");
    property p_alm_loop;
        s_wr(ADDR_ALARM_MINUTE) ##2 s_rd(ADDR_ALARM_MINUTE)
            |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 3);
    endproperty
    a_alm_loop: assert property (p_alm_loop)
        else $error("alarm minute readback differs");
    property p_ptime_sec;
        s_wr(ADDR_PACKED_TIME_SET) ##2 s_rd(ADDR_SECONDS_COUNT)
            |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 3);
    endproperty
    a_ptime_sec: assert property (p_ptime_sec)
        else $error("packed time seconds not loaded");
endmodule

bind rtccal_regs rtccal_regs_monitor u_mon (.sys_clk(sys_clk),
    .rst_n(rst_n), .clk_en(clk_en), .tick_32k(tick_32k),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .minute_counter(minute_counter), .hour_counter(hour_counter),
    .weekday_counter(weekday_counter), .minute_carry(minute_carry),
    .alarm_event(alarm_event));

// ---- bench/rtccal_host.sv ----
// rtccal_host: software side, single-cycle register reads and writes
// assumes the slave never stalls; a gap cycle follows every access
`timescale 1ns/10ps
module rtccal_host (
    input wire logic sys_clk,
    output logic [31:0] reg_addr = 32'h0,
    output logic [31:0] reg_wdata = 32'h0,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    input wire logic [31:0] reg_rdata
);
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 q = reg_rdata;
        @(posedge sys_clk);
    endtask
endmodule

// ---- bench/rtccal_regs_tb_top.sv ----
// rtccal_regs_tb_top: self-checking bench for rtccal_regs
// assumes tick_32k high for one cycle counts one 32 kHz tick
`timescale 1ns/10ps
module rtccal_regs_tb_top
    import rtccal_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic tick_32k = 1'b0;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, minute_carry, alarm_event;
    logic [6:0] minute_counter = 7'h7F;
    logic [5:0] hour_counter = 6'h0;
    logic [2:0] weekday_counter = 3'h0;
    logic [31:0] seed = 32'h6EAE0FBA;
    logic [31:0] mdl [logic [31:0]];
    int failures = 0;
    int num_checks = 0;
    int n_alarm = 0;
    logic [31:0] regs [12] = '{ADDR_WEEKDAY_BUFFER, ADDR_DAY_BUFFER,
        ADDR_MONTH_BUFFER, ADDR_YEAR_BUFFER, ADDR_PACKED_TIME_SET,
        ADDR_PACKED_CALENDAR_SET, ADDR_ERROR_CORRECTION,
        ADDR_SUBCOUNT_COMPARE, ADDR_ALARM_MINUTE, ADDR_ALARM_HOUR,
        ADDR_ALARM_WEEKDAY_ENABLE, ADDR_SECONDS_COUNT};

    rtccal_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .tick_32k(tick_32k), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .minute_counter(minute_counter), .hour_counter(hour_counter),
        .weekday_counter(weekday_counter), .minute_carry(minute_carry),
        .alarm_event(alarm_event));
    rtccal_host u_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (alarm_event === 1'b1) n_alarm <= n_alarm + 1;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] msk(input logic [31:0] a);
        case (a)
            ADDR_CONTROL: return 32'hF;
            ADDR_WEEKDAY_BUFFER: return 32'h7;
            ADDR_DAY_BUFFER: return 32'h3F;
            ADDR_MONTH_BUFFER: return 32'h1F;
            ADDR_YEAR_BUFFER, ADDR_ERROR_CORRECTION: return 32'hFF;
            ADDR_PACKED_TIME_SET: return 32'h3F7F7F;
            ADDR_PACKED_CALENDAR_SET: return 32'hFF1F3F07;
            ADDR_SUBCOUNT_COMPARE: return 32'h3FFFFF;
            ADDR_ALARM_MINUTE, ADDR_ALARM_WEEKDAY_ENABLE: return 32'h7F;
            ADDR_ALARM_HOUR: return 32'h3F;
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction
    task automatic chk(input string n, input logic [31:0] got,
                       input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic look(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_host.rd(a, q);
        chk($sformatf("reg %h", a), q, e);
    endtask
    task automatic put(input logic [31:0] a, input logic [31:0] d);
        u_host.wr(a, d);
        mdl[a] = d & msk(a);
        if (a == ADDR_PACKED_CALENDAR_SET) begin
            mdl[ADDR_YEAR_BUFFER] = {24'h0, d[31:24]};
            mdl[ADDR_MONTH_BUFFER] = {27'h0, d[20:16]};
            mdl[ADDR_DAY_BUFFER] = {26'h0, d[13:8]};
            mdl[ADDR_WEEKDAY_BUFFER] = {29'h0, d[2:0]};
        end
        if (a == ADDR_PACKED_TIME_SET)
            mdl[ADDR_SECONDS_COUNT] = {25'h0, d[6:0]};
        mdl[ADDR_PACKED_CALENDAR_SET] = {mdl[ADDR_YEAR_BUFFER][7:0],
            mdl[ADDR_MONTH_BUFFER][7:0], mdl[ADDR_DAY_BUFFER][7:0],
            mdl[ADDR_WEEKDAY_BUFFER][7:0]};
    endtask
    task automatic ticks(input int n);
        tick_32k <= 1'b1;
        repeat (n) @(posedge sys_clk);
        tick_32k <= 1'b0;
    endtask
    task automatic alarm_try(input logic [3:0] ctl, input logic [6:0] am,
        input logic [5:0] ah, input logic [6:0] en, input logic [2:0] wd,
        input logic [5:0] hr, input int ex);
        int n0;
        minute_counter <= 7'h7F;
        put(ADDR_CONTROL, {28'h0, ctl});
        put(ADDR_ALARM_MINUTE, {25'h0, am});
        put(ADDR_ALARM_HOUR, {26'h0, ah});
        put(ADDR_ALARM_WEEKDAY_ENABLE, {25'h0, en});
        hour_counter <= hr;
        weekday_counter <= wd;
        minute_counter <= am;
        n0 = n_alarm;
        repeat (3) @(posedge sys_clk);
        chk("alarm count", 32'(n_alarm - n0), 32'(ex));
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        foreach (regs[i]) mdl[regs[i]] = 32'h0;
        foreach (regs[i]) look(regs[i], 32'h0);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            put(ADDR_PACKED_CALENDAR_SET, {bcd(seed[7:0] % 100),
                bcd(1 + seed[11:8] % 12), bcd(1 + seed[20:16] % 28),
                bcd(seed[26:24] % 7)});
            put(ADDR_WEEKDAY_BUFFER, {29'h0, 3'(seed[30:28] % 7)});
            look(ADDR_WEEKDAY_BUFFER, mdl[ADDR_WEEKDAY_BUFFER]);
            put(ADDR_ERROR_CORRECTION, seed);
            put(ADDR_SUBCOUNT_COMPARE, 32'(31999 + seed[9:0]));
            put(ADDR_ALARM_WEEKDAY_ENABLE, seed);
            put(ADDR_ALARM_HOUR, {24'h0, bcd(1 + seed[15:12] % 12)});
            put(ADDR_ALARM_MINUTE, {24'h0, bcd(seed[5:0] % 60)});
            look(ADDR_ALARM_MINUTE, mdl[ADDR_ALARM_MINUTE]);
            put(ADDR_PACKED_TIME_SET, {8'h0, bcd(seed[4:0] % 24),
                bcd(seed[13:8] % 60), bcd(seed[21:16] % 60)});
            look(ADDR_SECONDS_COUNT, mdl[ADDR_SECONDS_COUNT]);
            foreach (regs[i]) look(regs[i], mdl[regs[i]]);
            put(32'h40006000, seed);
            look(32'h40006000, 32'h0);
        end
        // write strobe ignored while clock enable low
        clk_en <= 1'b0;
        u_host.wr(ADDR_WEEKDAY_BUFFER,
            {31'h0, mdl[ADDR_WEEKDAY_BUFFER][2:0] == 3'h0});
        clk_en <= 1'b1;
        look(ADDR_WEEKDAY_BUFFER, mdl[ADDR_WEEKDAY_BUFFER]);
        // compare source: old value governs the overflow after a live write
        put(ADDR_CONTROL, 32'h4);
        put(ADDR_SUBCOUNT_COMPARE, 32'd31999);
        put(ADDR_PACKED_TIME_SET, 32'h59);
        put(ADDR_CONTROL, 32'h5);
        look(ADDR_STATUS, 32'h0);
        u_host.wr(ADDR_SUBCOUNT_COMPARE, 32'd32010);
        look(ADDR_STATUS, 32'h1);
        ticks(31999);
        look(ADDR_SECONDS_COUNT, 32'h59);
        ticks(1);
        #1 chk("minute_carry", {31'h0, minute_carry}, 32'h1);
        @(posedge sys_clk);
        look(ADDR_SECONDS_COUNT, 32'h0);
        look(ADDR_STATUS, 32'h0);
        look(ADDR_SUBCOUNT_COMPARE, 32'd32010);
        // nominal count with correction: applied at 00 only
        put(ADDR_CONTROL, 32'h1);
        put(ADDR_ERROR_CORRECTION, 32'h82);
        put(ADDR_PACKED_TIME_SET, 32'h0);
        ticks(32769);
        look(ADDR_SECONDS_COUNT, 32'h0);
        ticks(1);
        look(ADDR_SECONDS_COUNT, 32'h1);
        put(ADDR_PACKED_TIME_SET, 32'h20);
        ticks(32767);
        look(ADDR_SECONDS_COUNT, 32'h20);
        // overflow held under wait, applied on release
        put(ADDR_CONTROL, 32'h3);
        ticks(1);
        look(ADDR_SECONDS_COUNT, 32'h20);
        look(ADDR_STATUS, 32'h2);
        put(ADDR_CONTROL, 32'h1);
        look(ADDR_SECONDS_COUNT, 32'h21);
        seed = lfsr(seed);
        for (int d = 0; d < 7; d++)
            alarm_try(4'h8, 7'h30, 6'h23, seed[6:0], 3'(d), 6'h23,
                      int'(seed[d]));
        alarm_try(4'h8, 7'h5A, 6'h23, 7'h7F, 3'h2, 6'h23, 0);
        alarm_try(4'h8, 7'h30, 6'h24, 7'h7F, 3'h2, 6'h24, 0);
        alarm_try(4'h0, 7'h15, 6'h32, 7'h7F, 3'h6, 6'h32, 1);
        alarm_try(4'h0, 7'h15, 6'h13, 7'h7F, 3'h6, 6'h13, 0);
        end_sim();
    end
endmodule
